/* File: sdmic_cfg.svh */
/*
  Constants for the smart DAC mode and interface control block.
  Assumes a 20 MHz clock; included by the package, both design modules, the checker and the bench.
*/
`ifndef SDMIC_CFG_SVH
`define SDMIC_CFG_SVH

`define SDMIC_CLK_HZ        20000000
`define SDMIC_SPI_BITS      5'h18
`define SDMIC_SPI_RD_BIT    23
`define SDMIC_I2C_BYTES     2'h3
`define SDMIC_I2C_BASE_ADDR 7'h48
`define SDMIC_DUTY_FULL     7'h7F
`define SDMIC_PWM_MIN_DIV   12'h003
`define SDMIC_THR_MIDSCALE  8'h80
`define SDMIC_GAIN_EXT      3'h0
`define SDMIC_GAIN_VDD      3'h1
`define SDMIC_GAIN_X1P5     3'h2
`define SDMIC_GAIN_X2       3'h3
`define SDMIC_GAIN_X3       3'h4
`define SDMIC_GAIN_X4       3'h5
`define SDMIC_PDN_UP        2'h0

`endif

/* File: sdmic_ctrl.sv */
/*
  Mode select, serial interface detection and lock, PWM pin sharing,
  animation enable and threshold DAC reference/gain selection.
  Assumes pins are open-drain with external pull-ups and that the
  register file answers regReadData one cycle after regRdStrobe.
*/
`include "sdmic_cfg.svh"

module sdmic_ctrl (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 clkEn,
  input  wire logic                 modeRefPin,
  input  wire logic                 pin0In,
  output logic                      pin0Out,
  output logic                      pin0Oe,
  input  wire logic                 pin1In,
  output logic                      pin1Out,
  output logic                      pin1Oe,
  input  wire logic                 pin2In,
  output logic                      pin2Out,
  output logic                      pin2Oe,
  input  wire logic                 spareSerialOutPinIn,
  output logic                      spareSerialOutPinOut,
  output logic                      spareSerialOutPinOe,
  input  wire logic [1:0]           addressSelectPin,
  input  wire logic                 spareSerialOutEn,
  input  wire logic [15:0]          regReadData,
  output logic                      regWrStrobe,
  output logic                      regRdStrobe,
  output logic [7:0]                regAddr,
  output logic [15:0]               regWrData,
  output sdmic_pkg::sdmic_bind_t    boundInterface,
  output logic                      programmingMode,
  input  wire logic [27:0]          pwmDuty,
  input  wire logic [19:0]          pwmFreqSel,
  input  wire logic                 animationEngineDisable,
  output logic                      animationRun,
  input  wire logic                 triggerInputCmp,
  output logic                      triggerInputLevel,
  input  wire logic                 triggerOutputRequest,
  output logic                      triggerOutputHigh,
  input  wire logic [1:0]           channelPowerdownSelect,
  input  wire logic                 internalRefEnable,
  input  wire logic [2:0]           channelGainSelect,
  output logic                      thresholdDacEnable,
  output logic [7:0]                thresholdDacCode,
  output logic                      internalRefOn,
  output sdmic_pkg::sdmic_ref_t     refSource,
  output sdmic_pkg::sdmic_gain_t    outputGain
);
  import sdmic_pkg::*;

  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [2:0]  prev;
    sdmic_bind_t binding;
    logic [4:0]  spiCnt;
    logic [23:0] spiShift;
    logic        rdPending;
    logic        sdoActive;
    logic [15:0] sdoShift;
    logic        sdoLow;
    sdmic_i2c_t  i2c;
    logic [3:0]  i2cBits;
    logic [1:0]  i2cBytes;
    logic [24:0] i2cShift;
    logic        ackLow;
    logic        wrStb;
    logic        rdStb;
    logic [7:0]  addr;
    logic [15:0] data;
    logic        trigOut;
    logic        dacEn;
    sdmic_ref_t  refSel;
    sdmic_gain_t gain;
    logic        intRef;
  } sdmic_ctrl_state_t;

  sdmic_ctrl_state_t st_reg;
  sdmic_ctrl_state_t st_next;

  logic       sclk;
  logic       sda;
  logic       syncPin;
  logic       modeProg;
  logic       sclRise;
  logic       sclFall;
  logic       i2cStart;
  logic       i2cStop;
  logic       syncRise;
  logic       syncLow;
  logic [6:0] myAddr;
  logic [3:0] pwmLow;

  // synchronised copies of pins; sync1 feeds only sync2
  assign sclk      = st_reg.sync2[0];
  assign sda       = st_reg.sync2[1];
  assign syncPin   = st_reg.sync2[2];
  assign modeProg  = st_reg.sync2[4];
  assign sclRise   = sclk & ~st_reg.prev[0];
  assign sclFall   = ~sclk & st_reg.prev[0];
  assign i2cStart  = sclk & st_reg.prev[0] & ~sda & st_reg.prev[1];
  assign i2cStop   = sclk & st_reg.prev[0] & sda & ~st_reg.prev[1];
  assign syncRise  = syncPin & ~st_reg.prev[2];
  assign syncLow   = ~syncPin;
  assign myAddr    = `SDMIC_I2C_BASE_ADDR
                     | {5'h00, st_reg.sync2[7:6]};

  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = {addressSelectPin, triggerInputCmp, modeRefPin,
                     spareSerialOutPinIn, pin2In, pin1In, pin0In};
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2[2:0];
    st_next.wrStb = 1'b0;
    st_next.rdStb = 1'b0;
    // read data is taken one cycle after the read strobe
    st_next.rdPending = st_reg.rdStb;

    // serial logic is idle in standalone mode, pins belong to PWM
    if (!modeProg) begin
      st_next.spiCnt    = 5'h00;
      st_next.i2c       = I2C_IDLE;
      st_next.ackLow    = 1'b0;
      st_next.sdoActive = 1'b0;
      st_next.sdoLow    = 1'b0;
    end else begin
      // SPI: frame while sync low, data taken on falling clock edge
      if (syncLow && sclFall && st_reg.spiCnt != `SDMIC_SPI_BITS) begin
        st_next.spiShift = {st_reg.spiShift[22:0], sda};
        st_next.spiCnt   = st_reg.spiCnt + 5'h01;
      end
      if (syncLow && sclRise && st_reg.sdoActive) begin
        st_next.sdoLow   = ~st_reg.sdoShift[15];
        st_next.sdoShift = {st_reg.sdoShift[14:0], 1'b1};
      end
      if (syncRise) begin
        st_next.spiCnt    = 5'h00;
        st_next.sdoActive = 1'b0;
        st_next.sdoLow    = 1'b0;
        if (st_reg.spiCnt == `SDMIC_SPI_BITS
            && st_reg.binding != BIND_I2C) begin
          st_next.binding = BIND_SPI;
          st_next.addr = st_reg.spiShift[22:15];
          st_next.data = st_reg.spiShift[15:0];
          if (st_reg.spiShift[`SDMIC_SPI_RD_BIT]) begin
            // readback needs the spare pin as output
            st_next.rdStb     = spareSerialOutEn;
          end else begin
            st_next.wrStb = 1'b1;
          end
        end
      end
      if (st_reg.rdPending) begin
        st_next.sdoShift  = regReadData;
        st_next.sdoActive = 1'b1;
      end

      // I2C: address byte, register byte, two data bytes, stop
      case (st_reg.i2c)
        I2C_IDLE: begin
        end
        I2C_RX: begin
          if (sclRise) begin
            st_next.i2cShift = {st_reg.i2cShift[23:0], sda};
            st_next.i2cBits  = st_reg.i2cBits + 4'h1;
          end else if (sclFall && st_reg.i2cBits == 4'h8) begin
            st_next.i2cBits = 4'h0;
            if (st_reg.i2cBytes == 2'h0
                && (st_reg.i2cShift[7:0] != {myAddr, 1'b0}
                    || st_reg.binding == BIND_SPI)) begin
              st_next.i2c = I2C_SKIP;
            end else begin
              st_next.ackLow = 1'b1;
              st_next.i2c    = I2C_ACK;
            end
          end
        end
        I2C_ACK: begin
          if (sclFall) begin
            st_next.ackLow = 1'b0;
            st_next.i2c    = I2C_RX;
            if (st_reg.i2cBytes != `SDMIC_I2C_BYTES) begin
              st_next.i2cBytes = st_reg.i2cBytes + 2'h1;
            end
          end
        end
        I2C_SKIP: begin
        end
        default: begin
          st_next.i2c = I2C_IDLE;
        end
      endcase
      if (i2cStop) begin
        st_next.i2c    = I2C_IDLE;
        st_next.ackLow = 1'b0;
        // the scl rise ahead of a stop shifts one spare bit in
        if (st_reg.i2c == I2C_RX && st_reg.i2cBits == 4'h1
            && st_reg.i2cBytes == `SDMIC_I2C_BYTES
            && st_reg.binding != BIND_SPI) begin
          st_next.binding = BIND_I2C;
          st_next.addr    = st_reg.i2cShift[24:17];
          st_next.data    = st_reg.i2cShift[16:1];
          st_next.wrStb = 1'b1;
        end
      end else if (i2cStart) begin
        st_next.i2c      = I2C_RX;
        st_next.i2cBits  = 4'h0;
        st_next.i2cBytes = 2'h0;
        st_next.ackLow   = 1'b0;
      end
    end

    // trigger output is a rail-to-rail level in standalone mode
    st_next.trigOut = ~modeProg & triggerOutputRequest;

    // reference and gain selection for the threshold DAC
    st_next.dacEn  = (channelPowerdownSelect == `SDMIC_PDN_UP);
    st_next.intRef = internalRefEnable;
    st_next.refSel = REF_VDD;
    st_next.gain   = GAIN_X1;
    if (channelGainSelect == `SDMIC_GAIN_EXT) begin
      st_next.refSel = REF_EXT;
    end else if (internalRefEnable) begin
      if (channelGainSelect == `SDMIC_GAIN_X1P5) begin
        st_next.refSel = REF_INT;
        st_next.gain   = GAIN_X1P5;
      end else if (channelGainSelect == `SDMIC_GAIN_X2) begin
        st_next.refSel = REF_INT;
        st_next.gain   = GAIN_X2;
      end else if (channelGainSelect == `SDMIC_GAIN_X3) begin
        st_next.refSel = REF_INT;
        st_next.gain   = GAIN_X3;
      end else if (channelGainSelect == `SDMIC_GAIN_X4) begin
        st_next.refSel = REF_INT;
        st_next.gain   = GAIN_X4;
      end
    end
  end

  // binding is never cleared by logic; only reset restarts detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg      <= '0;
      st_reg.binding <= BIND_NONE;
      st_reg.refSel  <= REF_VDD;
      st_reg.gain <= GAIN_X1;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gPwm
      sdmic_pwm_chan uPwm (
        .clk     (clk),
        .rst_b   (rst_b),
        .clkEn   (clkEn),
        .run     (~modeProg),
        .duty    (pwmDuty[g*7 +: 7]),
        .freqSel (pwmFreqSel[g*5 +: 5]),
        .pullLow (pwmLow[g])
      );
    end
  endgenerate

  // every pin drives low or floats; high comes from pull-ups
  assign pin0Out              = 1'b0;
  assign pin1Out              = 1'b0;
  assign pin2Out              = 1'b0;
  assign spareSerialOutPinOut = 1'b0;
  assign pin0Oe  = modeProg ? 1'b0 : pwmLow[0];
  assign pin1Oe  = modeProg ? st_reg.ackLow : pwmLow[1];
  assign pin2Oe  = modeProg ? 1'b0 : pwmLow[2];
  assign spareSerialOutPinOe = modeProg
         ? (st_reg.sdoLow & spareSerialOutEn) : pwmLow[3];

  assign regWrStrobe        = st_reg.wrStb;
  assign regRdStrobe        = st_reg.rdStb;
  assign regAddr            = st_reg.addr;
  assign regWrData          = st_reg.data;
  assign boundInterface     = st_reg.binding;
  assign programmingMode    = modeProg;
  assign animationRun       = ~modeProg & ~animationEngineDisable;
  assign triggerInputLevel  = st_reg.sync2[5];
  assign triggerOutputHigh  = st_reg.trigOut;
  assign thresholdDacEnable = st_reg.dacEn;
  assign thresholdDacCode   = `SDMIC_THR_MIDSCALE;
  assign internalRefOn      = st_reg.intRef;
  assign refSource          = st_reg.refSel;
  assign outputGain         = st_reg.gain;
endmodule : sdmic_ctrl

/* File: sdmic_ctrl_props.sv */
/*
  Port checker for sdmic_ctrl, bound to every instance below.
  Assumes clkEn is held high, so every clock edge advances the state.
*/
`include "sdmic_cfg.svh"

module sdmic_ctrl_props (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   programmingMode,
  input wire logic                   pin0Out,
  input wire logic                   pin1Out,
  input wire logic                   pin2Out,
  input wire logic                   spareSerialOutPinOut,
  input wire logic                   spareSerialOutEn,
  input wire logic                   regWrStrobe,
  input wire logic                   regRdStrobe,
  input wire sdmic_pkg::sdmic_bind_t boundInterface,
  input wire logic                   animationEngineDisable,
  input wire logic                   animationRun,
  input wire logic                   internalRefEnable,
  input wire logic                   internalRefOn,
  input wire logic [1:0]             channelPowerdownSelect,
  input wire logic                   thresholdDacEnable,
  input wire sdmic_pkg::sdmic_ref_t  refSource,
  input wire sdmic_pkg::sdmic_gain_t outputGain
);
  timeunit 1ns;
  timeprecision 1ns;
  import sdmic_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_od;
    (pin0Out | pin1Out | pin2Out | spareSerialOutPinOut) == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_bind;
    boundInterface != BIND_NONE |=> $stable(boundInterface);
  endproperty
  a_bind: assert property (p_bind) else $error("binding moved");
  property p_prog;
    regWrStrobe |-> programmingMode;
  endproperty
  a_prog: assert property (p_prog) else $error("write in standalone");
  property p_rd;
    regRdStrobe |-> spareSerialOutEn;
  endproperty
  a_rd: assert property (p_rd) else $error("read without serial out");
  property p_anim;
    animationRun == (!programmingMode && !animationEngineDisable);
  endproperty
  a_anim: assert property (p_anim) else $error("animation run wrong");
  property p_vdd;
    refSource == REF_VDD |-> outputGain == GAIN_X1;
  endproperty
  a_vdd: assert property (p_vdd) else $error("supply gain not one");
  property p_iref;
    !$past(internalRefEnable) |-> !internalRefOn;
  endproperty
  a_iref: assert property (p_iref) else $error("reference on early");
  property p_dacen;
    thresholdDacEnable |-> $past(channelPowerdownSelect) == `SDMIC_PDN_UP;
  endproperty
  a_dacen: assert property (p_dacen) else $error("dac on while down");
endmodule : sdmic_ctrl_props

bind sdmic_ctrl sdmic_ctrl_props i_sdmic_ctrl_props (
  .clk, .rst_b, .programmingMode, .pin0Out, .pin1Out, .pin2Out,
  .spareSerialOutPinOut, .spareSerialOutEn, .regWrStrobe, .regRdStrobe,
  .boundInterface, .animationEngineDisable, .animationRun,
  .internalRefEnable, .internalRefOn, .channelPowerdownSelect,
  .thresholdDacEnable, .refSource, .outputGain
);

/* File: sdmic_ctrl_tb_top.sv */
/*
  Self-checking bench for sdmic_ctrl with the host model on its pins.
  Assumes open-drain pins with pull-ups, resolved here.
*/
`include "sdmic_cfg.svh"

module sdmic_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sdmic_pkg::*;
  localparam logic [23:0] wrFrame = 24'h1AB53C;
  localparam logic [23:0] rdFrame = 24'h8A0000;
  logic        clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, modeRefPin = 1'b1;
  logic        spareSerialOutEn = 1'b0, animationEngineDisable = 1'b0;
  logic        triggerInputCmp = 1'b0, triggerOutputRequest = 1'b0;
  logic        internalRefEnable = 1'b0, sclD, sdaD, syncD;
  logic [1:0]  addressSelectPin = 2'h0, channelPowerdownSelect = 2'h1;
  logic [2:0]  channelGainSelect = `SDMIC_GAIN_VDD;
  logic [27:0] pwmDuty = 28'h0;
  logic [19:0] pwmFreqSel = 20'h0;
  logic [15:0] regReadData = 16'hA55A, regWrData, lastData;
  logic [7:0]  regAddr, thresholdDacCode, lastAddr;
  logic        pin0Out, pin0Oe, pin1Out, pin1Oe, pin2Out, pin2Oe;
  logic        spareSerialOutPinOut, spareSerialOutPinOe, regWrStrobe;
  logic        regRdStrobe, programmingMode, animationRun, internalRefOn;
  logic        triggerInputLevel, triggerOutputHigh, thresholdDacEnable;
  sdmic_bind_t boundInterface;
  sdmic_ref_t  refSource;
  sdmic_gain_t outputGain;
  wire logic   pin0In = sclD & ~pin0Oe;
  wire logic   pin1In = sdaD & ~pin1Oe;
  wire logic   pin2In = syncD & ~pin2Oe;
  wire logic   spareSerialOutPinIn = ~spareSerialOutPinOe;
  int          n_errors = 0, n_tests = 0, nWr = 0, nRd = 0, nSdo = 0;

  sdmic_ctrl i_sdmic_ctrl (.clk, .rst_b, .clkEn, .modeRefPin, .pin0In,
    .pin0Out, .pin0Oe, .pin1In, .pin1Out, .pin1Oe, .pin2In, .pin2Out,
    .pin2Oe, .spareSerialOutPinIn, .spareSerialOutPinOut,
    .spareSerialOutPinOe, .addressSelectPin, .spareSerialOutEn,
    .regReadData, .regWrStrobe, .regRdStrobe, .regAddr, .regWrData,
    .boundInterface, .programmingMode, .pwmDuty, .pwmFreqSel,
    .animationEngineDisable, .animationRun, .triggerInputCmp,
    .triggerInputLevel, .triggerOutputRequest, .triggerOutputHigh,
    .channelPowerdownSelect, .internalRefEnable, .channelGainSelect,
    .thresholdDacEnable, .thresholdDacCode, .internalRefOn, .refSource,
    .outputGain);
  sdmic_host i_sdmic_host (.sdaLine(pin1In), .sclDrive(sclD),
    .sdaDrive(sdaD), .syncDrive(syncD));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    nSdo += (spareSerialOutPinOe === 1'b1 && programmingMode === 1'b1);
    nRd += (regRdStrobe === 1'b1);
    if (regWrStrobe === 1'b1) begin
      nWr++;
      lastAddr = regAddr;
      lastData = regWrData;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic do_reset();
    rst_b = 1'b0;
    tick(10);
    rst_b = 1'b1;
    tick(4);
  endtask : do_reset
  task automatic next_rise(output int n);
    logic was;
    for (n = 1; n < 5000; n++) begin
      was = pin1Oe;
      tick(1);
      if (was === 1'b0 && pin1Oe === 1'b1) return;
    end
    n_errors++;
    $display("BAD pwm edge never came");
    end_of_test();
  endtask : next_rise

  task automatic t_reset_state();
    check("bind", boundInterface, BIND_NONE);
    check("ref", refSource, REF_VDD);
    check("gain", outputGain, GAIN_X1);
    check("iref", internalRefOn, 1'b0);
    check("code", thresholdDacCode, `SDMIC_THR_MIDSCALE);
    $display("test reset_state done");
  endtask : t_reset_state

  task automatic t_ref_gain();
    logic [31:0] er, eg;
    for (int e = 0; e < 2; e++) begin
      for (int g = 0; g < 6; g++) begin
        internalRefEnable = e[0];
        channelGainSelect = g[2:0];
        tick(3);
        er = g == 0 ? REF_EXT : (g == 1 || e == 0) ? REF_VDD : REF_INT;
        eg = (g < 2 || e == 0) ? GAIN_X1 : sdmic_gain_t'(g - 1);
        check("ref", refSource, er);
        check("gain", outputGain, eg);
        check("iref", internalRefOn, e[0]);
      end
    end
    internalRefEnable = 1'b0;
    tick(3);
    clkEn = 1'b0;
    internalRefEnable = 1'b1;
    tick(3);
    check("freeze", internalRefOn, 1'b0);
    clkEn = 1'b1;
    internalRefEnable = 1'b0;
    for (int p = 0; p < 4; p++) begin
      channelPowerdownSelect = p[1:0];
      tick(3);
      check("dacen", thresholdDacEnable, p == `SDMIC_PDN_UP);
    end
    $display("test ref_gain done");
  endtask : t_ref_gain

  task automatic t_spi();
    int w0, r0, s0, nk;
    w0 = nWr;
    s0 = nSdo;
    i_sdmic_host.spi(wrFrame);
    check("spiwr", nWr - w0, 1);
    check("spiaddr", lastAddr, wrFrame[22:15]);
    check("spidata", lastData, wrFrame[15:0]);
    check("bind", boundInterface, BIND_SPI);
    i_sdmic_host.i2c({`SDMIC_I2C_BASE_ADDR, 1'b0, 24'h3C9A5F}, nk);
    check("i2cnack", nk, 4);
    check("i2cwr", nWr - w0, 1);
    r0 = nRd;
    i_sdmic_host.spi(rdFrame);
    check("rdoff", nRd - r0, 0);
    check("sdooff", nSdo - s0, 0);
    spareSerialOutEn = 1'b1;
    i_sdmic_host.spi(rdFrame);
    check("rdon", nRd - r0, 1);
    i_sdmic_host.spi(rdFrame);
    check("sdoon", nSdo > s0, 1);
    spareSerialOutEn = 1'b0;
    $display("test spi done");
  endtask : t_spi

  task automatic t_i2c();
    int w0, nk;
    logic [6:0] a;
    for (int s = 0; s < 4; s++) begin
      addressSelectPin = s[1:0];
      do_reset();
      a = `SDMIC_I2C_BASE_ADDR | s[6:0];
      w0 = nWr;
      i_sdmic_host.i2c({a ^ 7'h01, 1'b0, 24'h3C9A5F}, nk);
      check("nack", nk, 4);
      check("unbound", boundInterface, BIND_NONE);
      i_sdmic_host.i2c({a, 1'b0, 24'h3C9A5F}, nk);
      check("ack", nk, 0);
      check("i2cwr", nWr - w0, 1);
      check("i2caddr", {lastAddr, lastData}, 24'h3C9A5F);
      check("bind", boundInterface, BIND_I2C);
    end
    i_sdmic_host.spi(wrFrame);
    check("spiwr", nWr - w0, 1);
    do_reset();
    check("bind", boundInterface, BIND_NONE);
    $display("test i2c done");
  endtask : t_i2c

  task automatic t_standalone();
    int w0, n0, n3, n;
    logic [4:0] f;
    pwmDuty = {7'h00, 7'h7F, 7'h40, `SDMIC_DUTY_FULL};
    modeRefPin = 1'b0;
    tick(4);
    check("mode", programmingMode, 1'b0);
    for (int v = 0; v < 2; v++) begin
      animationEngineDisable = v[0];
      triggerOutputRequest = ~v[0];
      triggerInputCmp = v[0];
      tick(4);
      check("anim", animationRun, !v[0]);
      check("trigout", triggerOutputHigh, !v[0]);
      check("trigin", triggerInputLevel, v[0]);
    end
    w0 = nWr;
    i_sdmic_host.spi(wrFrame);
    check("nowrite", nWr - w0, 0);
    n0 = 0;
    n3 = 0;
    for (int i = 0; i < 800; i++) begin
      tick(1);
      n0 += (pin0Oe !== 1'b0) + (pin2Oe !== 1'b0);
      n3 += (spareSerialOutPinOe === 1'b1);
    end
    check("dutyfull", n0, 0);
    check("dutyzero", n3 > 700, 1);
    for (int k = 0; k < 2; k++) begin
      f = 5'(k * 5);
      pwmFreqSel = {10'h0, f, 5'h0};
      repeat (3) next_rise(n);
      check("period", n, (128 * 3 * (1 + f[1:0])) << f[4:2]);
    end
    $display("test standalone done");
  endtask : t_standalone

  initial begin
    do_reset();
    t_reset_state();
    t_ref_gain();
    t_spi();
    t_i2c();
    t_standalone();
    end_of_test();
  end
endmodule : sdmic_ctrl_tb_top

/* File: sdmic_host.sv */
/*
  Host model: bit-banged SPI and I2C master on open-drain lines.
  Assumes pull-ups on every line; a drive of one means released.
*/
module sdmic_host (
  input  wire logic sdaLine,
  output logic      sclDrive,
  output logic      sdaDrive,
  output logic      syncDrive
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclDrive = 1'b1;
    sdaDrive = 1'b1;
    syncDrive = 1'b1;
  end

  // clock idles high between frames, data sampled by the device on falls
  task automatic spi(input logic [23:0] w);
    int hp;
    hp = w[23] ? 400 : 200;
    syncDrive = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdaDrive = w[i];
      #hp sclDrive = 1'b0;
      #hp sclDrive = 1'b1;
    end
    #hp syncDrive = 1'b1;
    sdaDrive = 1'b1;
    #2000;
  endtask : spi

  // data moves mid-low so it never looks like a start or stop
  task automatic i2c(input logic [31:0] w, output int nacks);
    nacks = 0;
    sdaDrive = 1'b0;
    #200 sclDrive = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      #100 sdaDrive = w[i];
      #100 sclDrive = 1'b1;
      #200 sclDrive = 1'b0;
      if (i % 8 == 0) begin
        #100 sdaDrive = 1'b1;
        #100 sclDrive = 1'b1;
        #200 nacks += (sdaLine !== 1'b0);
        sclDrive = 1'b0;
      end
    end
    #100 sdaDrive = 1'b0;
    #100 sclDrive = 1'b1;
    #200 sdaDrive = 1'b1;
    #2000;
  endtask : i2c
endmodule : sdmic_host

/* File: sdmic_pkg.sv */
/*
  Types shared by the mode and interface control block.
  Assumes sdmic_cfg.svh is reachable on the include path.
*/
`include "sdmic_cfg.svh"

package sdmic_pkg;
  typedef enum logic [1:0] {BIND_NONE, BIND_I2C, BIND_SPI} sdmic_bind_t;
  typedef enum logic [1:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_SKIP} sdmic_i2c_t;
  typedef enum logic [1:0] {REF_VDD, REF_INT, REF_EXT} sdmic_ref_t;
  typedef enum logic [2:0] {
    GAIN_X1, GAIN_X1P5, GAIN_X2, GAIN_X3, GAIN_X4
  } sdmic_gain_t;
endpackage : sdmic_pkg

/* File: sdmic_pwm_chan.sv */
/*
  One PWM channel: 7-bit duty, 32 frequency settings, open-drain drive.
  Assumes clk and the clock enable come from the parent block.
*/
`include "sdmic_cfg.svh"

module sdmic_pwm_chan (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic       run,
  input  wire logic [6:0] duty,
  input  wire logic [4:0] freqSel,
  output logic            pullLow
);
  import sdmic_pkg::*;

  typedef struct packed {
    logic [11:0] presc;
    logic [6:0]  phase;
    logic        low;
  } sdmic_pwm_state_t;

  sdmic_pwm_state_t st_reg;
  sdmic_pwm_state_t st_next;
  logic [11:0]      divLimit;

  // nominal divider, oscillator error is not trimmed out
  always_comb begin
    divLimit = 12'((`SDMIC_PWM_MIN_DIV * {10'h000, freqSel[1:0]}
               + `SDMIC_PWM_MIN_DIV) << freqSel[4:2]);
  end

  always_comb begin
    st_next = st_reg;
    if (!run) begin
      st_next.presc = 12'h000;
      st_next.phase = 7'h00;
      st_next.low   = 1'b0;
    end else begin
      if (st_reg.presc >= divLimit - 12'h001) begin
        st_next.presc = 12'h000;
        st_next.phase = st_reg.phase + 7'h01;
      end else begin
        st_next.presc = st_reg.presc + 12'h001;
      end
      // full code holds the line released for 100 % duty
      st_next.low = (duty != `SDMIC_DUTY_FULL)
                    && (st_next.phase >= duty);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign pullLow = st_reg.low;
endmodule : sdmic_pwm_chan
